// ### yfl_regs.vh
// register offsets, fields and reset values of the capture fifo level and image size slice
`ifndef YFL_REGS_VH
`define YFL_REGS_VH
`define YFL_OFS_VALID_LOW 16'h2828
`define YFL_OFS_VALID_HIGH 16'h282e
`define YFL_OFS_WIDTH 16'h2872
`define YFL_OFS_HEIGHT 16'h2874
`define YFL_DMA_PORT_ADDR 32'h3000_0000
`define YFL_RST_VALID_LOW 16'h0000
`define YFL_RST_VALID_HIGH 16'h0000
`define YFL_RST_WIDTH 11'h000
`define YFL_RST_HEIGHT 11'h000
`define YFL_EXT_CNT_LSB 8
`define YFL_SIZE_MSB 10
`define YFL_MODE_DISPLAY 3'h1
`define YFL_MODE_CAPTURE_A 3'h3
`define YFL_MODE_CAPTURE_B 3'h7
`define YFL_CNT_WIDTH 18
`define YFL_RST_COUNT 18'h00000
`endif

// ### yfl_slice.v
// capture fifo valid-word count, image size registers and pseudo sync generator
//
// Contract
// - the fifo data port answers only the dma engine at its dma-space address, never the host bus.
// - the block reports read-only how many 16-bit words the fifo holds.
// - that count is 18 bits: low 16 in one register, top two in bits 9-8 of the extension register.
// - extension register bits 5-4 and 1-0 always read as zero.
// - image width in pixels is the 11-bit horizontal field plus one.
// - image height in lines is the 11-bit vertical field plus one.
// - in yuv display mode width and height drive pseudo frame and line sync to the resizer.
// - in either capture mode the size settings have no effect.
// - mode 001b is display with dma writing the fifo; 011b and 111b capture with dma reading it.
// - in capture modes the fifo data port is the read port the dma engine drains.
`include "yfl_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module yfl_slice (
	// clock and reset
	input wire clk,
	input wire nrst,
	// host register port
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	// mode from the capture mode register
	input wire [2:0] capture_mode,
	// dma engine port to the fifo
	input wire [31:0] dma_addr,
	input wire dma_wr,
	input wire dma_rd,
	input wire [15:0] dma_wdata,
	output reg [15:0] dma_rdata,
	output reg dma_ack,
	// fifo storage side
	input wire fifo_push,
	input wire fifo_pop,
	input wire [15:0] fifo_rdata,
	output reg fifo_wr_stb,
	output reg fifo_rd_stb,
	output reg [15:0] fifo_wdata,
	// pseudo sync to the view resizer
	input wire pixel_en,
	output reg frame_sync,
	output reg line_sync,
	output reg pixel_valid
);

	reg [17:0] count_q;
	reg [17:0] count_d;
	reg [10:0] width_q;
	reg [10:0] width_d;
	reg [10:0] height_q;
	reg [10:0] height_d;
	reg [10:0] hcnt_q;
	reg [10:0] hcnt_d;
	reg [10:0] vcnt_q;
	reg [10:0] vcnt_d;
	reg [15:0] reg_rdata_d;
	reg [15:0] dma_rdata_d;
	reg dma_ack_d;
	reg fifo_wr_stb_d;
	reg fifo_rd_stb_d;
	reg [15:0] fifo_wdata_d;
	reg frame_sync_d;
	reg line_sync_d;
	reg pixel_valid_d;
	wire dma_hit;
	wire dma_req;
	wire mode_display;
	wire mode_capture;
	wire wr_width;
	wire wr_height;
	wire line_end;
	wire frame_end;
	wire line_start;
	wire frame_start;

	// exact match of a host address against an offset
	function addr_is;
		input [15:0] a;
		input [15:0] ofs;
		begin
			addr_is = (a == ofs);
		end
	endfunction

	// last position of a size field, span is field plus one
	function at_last;
		input [10:0] cnt;
		input [10:0] size;
		begin
			at_last = (cnt == size);
		end
	endfunction

	// one step of an 11-bit position counter
	function [10:0] step11;
		input [10:0] cnt;
		begin
			step11 = cnt + 11'h001;
		end
	endfunction

	// extension word, count bits 17-16 at 9-8
	function [15:0] ext_word;
		input [17:0] cnt;
		begin
			ext_word = {6'h00, cnt[17:16], 8'h00};
		end
	endfunction

	function is_capture;
		input [2:0] m;
		begin
			is_capture = (m == `YFL_MODE_CAPTURE_A) || (m == `YFL_MODE_CAPTURE_B);
		end
	endfunction

	assign mode_display = (capture_mode == `YFL_MODE_DISPLAY);
	assign mode_capture = is_capture(capture_mode);
	assign dma_hit = (dma_addr == `YFL_DMA_PORT_ADDR);
	assign dma_req = dma_hit && (dma_wr || dma_rd);
	assign wr_width = reg_wr && addr_is(reg_addr, `YFL_OFS_WIDTH);
	assign wr_height = reg_wr && addr_is(reg_addr, `YFL_OFS_HEIGHT);
	assign line_end = at_last(hcnt_q, width_q);
	assign frame_end = line_end && at_last(vcnt_q, height_q);
	assign line_start = (hcnt_q == 11'h000);
	assign frame_start = line_start && (vcnt_q == 11'h000);

	// occupancy counter
	always @* begin
		count_d = count_q;
		case ({fifo_push, fifo_pop})
			2'b10: begin
				count_d = count_q + 18'h00001;
			end
			2'b01: begin
				if (count_q != 18'h00000) begin
					count_d = count_q - 18'h00001;
				end
			end
			default: begin
				count_d = count_q;
			end
		endcase
	end

	// host read mux
	always @* begin
		reg_rdata_d = 16'h0000;
		case (reg_addr)
			`YFL_OFS_VALID_LOW: begin
				reg_rdata_d = count_q[15:0];
			end
			`YFL_OFS_VALID_HIGH: begin
				reg_rdata_d = ext_word(count_q);
			end
			`YFL_OFS_WIDTH: begin
				reg_rdata_d = 16'h0000;
			end
			`YFL_OFS_HEIGHT: begin
				reg_rdata_d = 16'h0000;
			end
			default: begin
				reg_rdata_d = 16'h0000;
			end
		endcase
	end

	// write-only size fields
	always @* begin
		width_d = width_q;
		height_d = height_q;
		if (wr_width) begin
			width_d = reg_wdata[`YFL_SIZE_MSB:0];
		end
		if (wr_height) begin
			height_d = reg_wdata[`YFL_SIZE_MSB:0];
		end
	end

	// occupancy count
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= `YFL_RST_COUNT;
		end else begin
			count_q <= count_d;
		end
	end

	// host read data, held until the next read
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= reg_rdata_d;
		end
	end

	// size registers
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			width_q <= `YFL_RST_WIDTH;
			height_q <= `YFL_RST_HEIGHT;
		end else begin
			width_q <= width_d;
			height_q <= height_d;
		end
	end

	// dma-only fifo data port, strobes
	always @* begin
		dma_ack_d = dma_req;
		fifo_wr_stb_d = dma_hit && dma_wr && mode_display;
		fifo_rd_stb_d = dma_hit && dma_rd && mode_capture;
	end

	// dma-only fifo data port, data
	always @* begin
		fifo_wdata_d = fifo_wdata;
		dma_rdata_d = dma_rdata;
		if (dma_hit && dma_wr) begin
			fifo_wdata_d = dma_wdata;
		end
		if (dma_hit && dma_rd && mode_capture) begin
			dma_rdata_d = fifo_rdata;
		end
	end

	// dma strobes, registered
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dma_ack <= 1'b0;
			fifo_wr_stb <= 1'b0;
			fifo_rd_stb <= 1'b0;
		end else begin
			dma_ack <= dma_ack_d;
			fifo_wr_stb <= fifo_wr_stb_d;
			fifo_rd_stb <= fifo_rd_stb_d;
		end
	end

	// dma data, registered
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dma_rdata <= 16'h0000;
			fifo_wdata <= 16'h0000;
		end else begin
			dma_rdata <= dma_rdata_d;
			fifo_wdata <= fifo_wdata_d;
		end
	end

	// pseudo sync outputs, display mode only
	always @* begin
		pixel_valid_d = 1'b0;
		line_sync_d = 1'b0;
		frame_sync_d = 1'b0;
		if (mode_display && pixel_en) begin
			pixel_valid_d = 1'b1;
			line_sync_d = line_start;
			frame_sync_d = frame_start;
		end
	end

	// pseudo sync position, idle outside display mode
	always @* begin
		hcnt_d = hcnt_q;
		vcnt_d = vcnt_q;
		if (!mode_display) begin
			hcnt_d = 11'h000;
			vcnt_d = 11'h000;
		end else if (pixel_en) begin
			if (frame_end) begin
				hcnt_d = 11'h000;
				vcnt_d = 11'h000;
			end else if (line_end) begin
				hcnt_d = 11'h000;
				vcnt_d = step11(vcnt_q);
			end else begin
				hcnt_d = step11(hcnt_q);
			end
		end
	end

	// pseudo sync position counters
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hcnt_q <= 11'h000;
			vcnt_q <= 11'h000;
		end else begin
			hcnt_q <= hcnt_d;
			vcnt_q <= vcnt_d;
		end
	end

	// pseudo sync outputs, registered
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_sync <= 1'b0;
			line_sync <= 1'b0;
			pixel_valid <= 1'b0;
		end else begin
			frame_sync <= frame_sync_d;
			line_sync <= line_sync_d;
			pixel_valid <= pixel_valid_d;
		end
	end

endmodule
`default_nettype wire

// ### yfl_mon_monitor.sv
// assertions on the slice ports
`timescale 1ns/10ps
`default_nettype none
module yfl_mon (
	input wire logic clk, nrst, reg_rd, dma_wr, dma_rd, dma_ack, fifo_wr_stb, fifo_rd_stb,
	input wire logic pixel_en, frame_sync, line_sync, pixel_valid,
	input wire logic [15:0] reg_addr, reg_rdata,
	input wire logic [2:0] capture_mode,
	input wire logic [31:0] dma_addr
);
	wire logic hit = (dma_wr | dma_rd) & (dma_addr == 32'h30000000);
	wire logic cap = capture_mode == 3'h3 | capture_mode == 3'h7;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_ACK: assert property (hit |=> dma_ack) else $error("no ack");
	AST_NOACK: assert property (!hit |=> !dma_ack) else $error("stray ack");
	AST_RD: assert property (hit & dma_rd & cap |=> fifo_rd_stb) else $error("no pop");
	AST_WR: assert property (hit & dma_wr & capture_mode == 3'h1 |=> fifo_wr_stb)
		else $error("no push");
	AST_EXT: assert property (reg_rd & reg_addr == 16'h282e |=> !(reg_rdata & 16'hfcff))
		else $error("ext bits");
	AST_PV: assert property (pixel_en & capture_mode == 3'h1 |=> pixel_valid)
		else $error("no pixel");
	AST_CAP: assert property (cap [*2] |-> !(frame_sync | line_sync | pixel_valid))
		else $error("sync in capture");
	AST_FS: assert property (frame_sync |-> line_sync) else $error("frame w/o line");
endmodule
bind yfl_slice yfl_mon i_mon (.*);
`default_nettype wire

// ### yfl_fifo.sv
// fifo storage stand-in
`timescale 1ns/10ps
`default_nettype none
module yfl_fifo (
	input wire logic clk, fifo_wr_stb, fifo_rd_stb, bulk,
	output logic fifo_push, fifo_pop,
	output var logic [15:0] fifo_rdata
);
	initial fifo_rdata = 16'h0;
	assign fifo_push = fifo_wr_stb | bulk;
	assign fifo_pop = fifo_rd_stb;
	always @(posedge clk) fifo_rdata <= fifo_rdata + 16'h1357;
endmodule
`default_nettype wire

// ### test_yfl_slice.sv
// bench of the fifo level and size slice
`timescale 1ns/10ps
`default_nettype none
module test_yfl_slice;
	logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, dma_wr = 0, dma_rd = 0, pixel_en = 0;
	logic bulk = 0, fifo_push, fifo_pop, fifo_wr_stb, fifo_rd_stb, dma_ack;
	logic frame_sync, line_sync, pixel_valid;
	logic [15:0] reg_addr = 0, reg_wdata = 0, dma_wdata = 0, reg_rdata, dma_rdata;
	logic [15:0] fifo_rdata, fifo_wdata;
	logic [2:0] capture_mode = 0;
	logic [31:0] dma_addr = 0;
	int mismatches = 0, n_tests = 0, n_ls = 0, n_fs = 0;
	yfl_slice i_dut (.*);
	yfl_fifo i_fifo (.*);
	initial forever #5 clk = ~clk;
	always @(posedge clk) n_ls <= n_ls + line_sync;
	always @(posedge clk) n_fs <= n_fs + frame_sync;
	task check(string n, logic [17:0] s, e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task stop_test;
		if (mismatches == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task wr(logic [15:0] a, d);
		@(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1; end
		@(posedge clk) reg_wr <= 0;
	endtask
	task rd(logic [15:0] a, e);
		@(posedge clk) begin reg_addr <= a; reg_rd <= 1; end
		@(posedge clk) reg_rd <= 0;
		#1 check("reg", {2'h0, reg_rdata}, {2'h0, e});
	endtask
	task dma(logic [2:0] m, logic r, int n);
		logic [15:0] x;
		@(posedge clk) capture_mode <= m;
		repeat (n) @(posedge clk) begin
			dma_addr <= 32'h30000000;
			dma_rd <= r;
			dma_wr <= !r;
			dma_wdata <= dma_wdata + 16'h0101;
		end
		@(posedge clk) begin
			x = fifo_rdata;
			dma_rd <= 0;
			dma_wr <= 0;
		end
		#1 check("dma_ack", dma_ack, 1);
		if (r) check("dma_rdata", dma_rdata, x);
		else check("fifo_wdata", fifo_wdata, dma_wdata);
	endtask
	task t_fill;
		rd(16'h2828, 16'h0);
		rd(16'h2872, 16'h0);
		dma(3'h1, 0, 5);
		rd(16'h2828, 16'h5);
		wr(16'h282e, 16'hffff);
		rd(16'h282e, 16'h0);
		dma(3'h3, 1, 2);
		rd(16'h2828, 16'h3);
		dma(3'h7, 1, 4);
		rd(16'h2828, 16'h0);
	endtask
	task t_big;
		@(posedge clk) bulk <= 1;
		repeat (65540) @(posedge clk);
		bulk <= 0;
		rd(16'h2828, 16'h4);
		rd(16'h282e, 16'h0100);
	endtask
	task t_sync(logic [2:0] m, int e);
		int b, f;
		b = n_ls;
		f = n_fs;
		@(posedge clk) capture_mode <= m;
		repeat (4) begin
			@(posedge clk) pixel_en <= 1;
			@(posedge clk) pixel_en <= 0;
		end
		repeat (3) @(posedge clk);
		check("lines", 18'(n_ls - b), 18'(e));
		check("frames", 18'(n_fs - f), 18'(e));
	endtask
	initial begin
		#1_000_000;
		mismatches++;
		stop_test;
	end
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1;
		t_fill;
		t_big;
		wr(16'h2872, 16'h1);
		wr(16'h2874, 16'h0);
		t_sync(3'h1, 2);
		t_sync(3'h3, 0);
		stop_test;
	end
endmodule
`default_nettype wire
